// *** sdi_out_map.svh ***
// Offsets, field positions, reset values and timing counts of the SDI output stage.
`ifndef SDI_OUT_MAP_SVH
`define SDI_OUT_MAP_SVH
//
// Summary of operation
// - Insert payload ID packet in field 1, and in field 2 when enabled, on the programmed 11-bit line.
// - Field-2 line is ignored unless insertion and field-2 enable are both high.
// - Field-2 enable is disregarded while packet insertion is disabled.
// - Link A stream 1, and link B stream 1 in dual modes, carry inserted packets when insertion is enabled.
// - Link A stream 1 carries Y/C, Y, stream 1 or signal 1 Y per mode.
// - Link A stream 2 carries chroma, link A stream 2 or signal 1 chroma.
// - Link B streams serve only dual-link and level B, else unused.
// - External select high sends the four inputs, low sends internal streams.
// - SD without bypass repeats each serial bit eleven times.
// - 20-bit transceiver word; bypassed SD word sits on bits 19 to 10.
// - Cadence error rises when the enable pattern leaves 5/6/5/6.
// - Cadence error is meaningful only in SD with bypass low.
`define OFS_CTRL 5'h00
`define OFS_LINES 5'h04
`define OFS_UDW 5'h08
`define OFS_STATUS 5'h0c
`define CTRL_MODE_LSB 0
`define CTRL_LEVELB 2
`define CTRL_INSERT 3
`define CTRL_F2EN 4
`define CTRL_USEEXT 5
`define CTRL_BYPASS 6
`define LINES_F2_LSB 16
`define CTRL_RESET 32'h0000_0000
`define LINES_RESET 32'h0000_0000
`define UDW_RESET 32'h0000_0000
`define CAD_SHORT 4'h5
`define CAD_LONG 4'h6
`define REP_FACTOR 11
`define REP_PHASES 4'ha
`define PKT_LAST 4'ha
`define PKT_DID 8'h41
`define PKT_SDID 8'h01
`define PKT_DC 8'h04
`endif

// *** sdi_out_pkg.sv ***
// Types shared by the SDI output stage.
package sdi_out_pkg;
    typedef enum logic [1:0] {MODE_HD, MODE_SD, MODE_3G, MODE_BAD} mode_e;
    typedef enum logic {PKT_IDLE, PKT_SEND} pkt_state_e;
endpackage

// *** sdi_out_stage.sv ***
// SDI transmit output stage: packet insertion, stream select, word packing, cadence check.
`include "sdi_out_map.svh"
module sdi_out_stage (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic TX_CE,
    input wire logic HANC_START,
    input wire logic [10:0] LINE_IN,
    input wire logic FIELD2_IN,
    input wire logic [9:0] VID_A_Y_IN,
    input wire logic [9:0] VID_A_C_IN,
    input wire logic [9:0] VID_B_Y_IN,
    input wire logic [9:0] VID_B_C_IN,
    input wire logic [9:0] LINK_A_STREAM1_IN,
    input wire logic [9:0] LINK_A_STREAM2_IN,
    input wire logic [9:0] LINK_B_STREAM1_IN,
    input wire logic [9:0] LINK_B_STREAM2_IN,
    output logic [9:0] LINK_A_STREAM1_OUT,
    output logic [9:0] LINK_A_STREAM2_OUT,
    output logic [9:0] LINK_B_STREAM1_OUT,
    output logic [9:0] LINK_B_STREAM2_OUT,
    output logic [19:0] TXDATA,
    output logic CADENCE_ERR
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [9:0] anc(input logic [7:0] d);
        anc = {~^d, ^d, d};
    endfunction

    function automatic logic [9:0] pkt_word(input logic [3:0] i, input logic [31:0] u);
        logic [8:0] sum;
        sum = 9'h000;
        sum = sum + {1'b0, `PKT_DID} + {1'b0, `PKT_SDID} + {1'b0, `PKT_DC};
        sum = sum + {1'b0, u[7:0]} + {1'b0, u[15:8]} + {1'b0, u[23:16]} + {1'b0, u[31:24]};
        case (i)
            4'h0: pkt_word = 10'h000;
            4'h1, 4'h2: pkt_word = 10'h3ff;
            4'h3: pkt_word = anc(`PKT_DID);
            4'h4: pkt_word = anc(`PKT_SDID);
            4'h5: pkt_word = anc(`PKT_DC);
            4'h6: pkt_word = anc(u[7:0]);
            4'h7: pkt_word = anc(u[15:8]);
            4'h8: pkt_word = anc(u[23:16]);
            4'h9: pkt_word = anc(u[31:24]);
            default: pkt_word = {~sum[8], sum};
        endcase
    endfunction

    // Serial bit s of the 11-cycle pair lives in word bit s/11; bit 0 leaves first.
    function automatic logic [19:0] replicate(input logic [3:0] ph, input logic [19:0] pr);
        int s;
        replicate = 20'h00000;
        for (int j = 0; j < 20; j++) begin
            s = 32'(ph) * 20 + j;
            replicate[j] = pr[s / `REP_FACTOR];
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[b*8 +: 8] = n[b*8 +: 8];
            end
        end
    endfunction

    // ****************************************
    // Register slave
    // ****************************************
    logic [31:0] ctrl_r, ctrl_nxt, lines_r, lines_nxt, udw_r, udw_nxt, rdata_r, rdata_nxt;
    logic wait_r, wait_nxt, cad_err_r;
    sdi_out_pkg::pkt_state_e st_r;
    logic req;
    sdi_out_pkg::mode_e mode;
    logic level_b, ins_en, f2_en, use_ext, bypass, sd_rep, dual;

    assign req = AVS_READ | AVS_WRITE;
    assign mode = sdi_out_pkg::mode_e'(ctrl_r[`CTRL_MODE_LSB +: 2]);
    assign level_b = ctrl_r[`CTRL_LEVELB];
    assign ins_en = ctrl_r[`CTRL_INSERT];
    assign f2_en = ctrl_r[`CTRL_F2EN];
    assign use_ext = ctrl_r[`CTRL_USEEXT];
    assign bypass = ctrl_r[`CTRL_BYPASS];
    assign sd_rep = (mode == sdi_out_pkg::MODE_SD) && !bypass;
    assign dual = (mode == sdi_out_pkg::MODE_HD) || (mode == sdi_out_pkg::MODE_3G && level_b);

    always_comb begin
        ctrl_nxt = ctrl_r;
        lines_nxt = lines_r;
        udw_nxt = udw_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        if (req && wait_r) begin
            wait_nxt = 1'b0;
            case (AVS_ADDRESS)
                `OFS_CTRL: rdata_nxt = ctrl_r;
                `OFS_LINES: rdata_nxt = lines_r;
                `OFS_UDW: rdata_nxt = udw_r;
                `OFS_STATUS: rdata_nxt = {30'h00000000, st_r == sdi_out_pkg::PKT_SEND, cad_err_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        if (AVS_WRITE && !wait_r) begin
            case (AVS_ADDRESS)
                `OFS_CTRL: ctrl_nxt = merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000007f;
                `OFS_LINES: lines_nxt = merge(lines_r, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h07ff07ff;
                `OFS_UDW: udw_nxt = merge(udw_r, AVS_WRITEDATA, AVS_BYTEENABLE);
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_r <= `CTRL_RESET;
            lines_r <= `LINES_RESET;
            udw_r <= `UDW_RESET;
            rdata_r <= 32'h00000000;
            wait_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            lines_r <= lines_nxt;
            udw_r <= udw_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end
    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;

    // ****************************************
    // Payload ID insertion
    // ****************************************
    sdi_out_pkg::pkt_state_e st_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [9:0] o1a_r, o2a_r, o1b_r, o2b_r, o1a_nxt, o2a_nxt, o1b_nxt, o2b_nxt;
    logic hit, f2_hit;

    assign f2_hit = ins_en && f2_en && FIELD2_IN && (LINE_IN == lines_r[`LINES_F2_LSB +: 11]);
    assign hit = (ins_en && !FIELD2_IN && (LINE_IN == lines_r[10:0])) || f2_hit;

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        o1a_nxt = o1a_r;
        o2a_nxt = o2a_r;
        o1b_nxt = o1b_r;
        o2b_nxt = o2b_r;
        if (TX_CE) begin
            o1a_nxt = VID_A_Y_IN;
            o2a_nxt = VID_A_C_IN;
            o1b_nxt = dual ? VID_B_Y_IN : 10'h000;
            o2b_nxt = dual ? VID_B_C_IN : 10'h000;
            case (st_r)
                sdi_out_pkg::PKT_IDLE: begin
                    if (HANC_START && hit) begin
                        st_nxt = sdi_out_pkg::PKT_SEND;
                        idx_nxt = 4'h1;
                        o1a_nxt = pkt_word(4'h0, udw_r);
                        o1b_nxt = dual ? pkt_word(4'h0, udw_r) : 10'h000;
                    end
                end
                sdi_out_pkg::PKT_SEND: begin
                    o1a_nxt = pkt_word(idx_r, udw_r);
                    o1b_nxt = dual ? pkt_word(idx_r, udw_r) : 10'h000;
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r == `PKT_LAST) begin
                        st_nxt = sdi_out_pkg::PKT_IDLE;
                    end
                end
                default: st_nxt = sdi_out_pkg::PKT_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r <= sdi_out_pkg::PKT_IDLE;
            idx_r <= 4'h0;
            {o1a_r, o2a_r, o1b_r, o2b_r} <= 40'h0000000000;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            {o1a_r, o2a_r, o1b_r, o2b_r} <= {o1a_nxt, o2a_nxt, o1b_nxt, o2b_nxt};
        end
    end
    assign LINK_A_STREAM1_OUT = o1a_r;
    assign LINK_A_STREAM2_OUT = o2a_r;
    assign LINK_B_STREAM1_OUT = o1b_r;
    assign LINK_B_STREAM2_OUT = o2b_r;

    // ****************************************
    // Source select, packing and cadence
    // ****************************************
    logic [9:0] s1a_r, s2a_r, s1b_r, s2b_r, s1a_nxt, s2a_nxt, s1b_nxt, s2b_nxt;
    logic [9:0] wa_r, wb_r, wa_nxt, wb_nxt;
    logic [19:0] pair_r, pair_nxt, tx_r, tx_nxt;
    logic [3:0] ph_r, ph_nxt, gap_r, gap_nxt, last_r, last_nxt;
    logic half_r, half_nxt, lb_r, lb_nxt, err_nxt;
    logic [3:0] gap_now;

    assign gap_now = gap_r + 4'h1;

    always_comb begin
        {s1a_nxt, s2a_nxt, s1b_nxt, s2b_nxt} = {s1a_r, s2a_r, s1b_r, s2b_r};
        {wa_nxt, wb_nxt, pair_nxt, half_nxt} = {wa_r, wb_r, pair_r, half_r};
        {gap_nxt, last_nxt, err_nxt} = {gap_r, last_r, cad_err_r};
        ph_nxt = (ph_r == `REP_PHASES) ? ph_r : ph_r + 4'h1;
        lb_nxt = !lb_r;
        // one register stage for either source
        if (TX_CE) begin
            s1a_nxt = use_ext ? LINK_A_STREAM1_IN : o1a_r;
            s2a_nxt = use_ext ? LINK_A_STREAM2_IN : o2a_r;
            s1b_nxt = use_ext ? LINK_B_STREAM1_IN : o1b_r;
            s2b_nxt = use_ext ? LINK_B_STREAM2_IN : o2b_r;
            half_nxt = !half_r;
            if (half_r) begin
                wb_nxt = s1a_r;
            end else begin
                wa_nxt = s1a_r;
                pair_nxt = {wb_r, wa_r};
                ph_nxt = 4'h0;
            end
        end
        case (mode)
            sdi_out_pkg::MODE_SD: tx_nxt = bypass ? {s1a_r, 10'h000} : replicate(ph_r, pair_r);
            sdi_out_pkg::MODE_3G: tx_nxt = (level_b && lb_r) ? {s2b_r, s1b_r} : {s2a_r, s1a_r};
            default: tx_nxt = {s2a_r, s1a_r};
        endcase
        if (!sd_rep) begin
            {gap_nxt, last_nxt, err_nxt} = {4'h0, 4'h0, 1'b0};
        end else if (TX_CE) begin
            gap_nxt = 4'h0;
            last_nxt = gap_now;
            err_nxt = (gap_now != `CAD_SHORT && gap_now != `CAD_LONG) || (last_r == gap_now);
        end else if (gap_r != 4'hf) begin
            gap_nxt = gap_now;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {s1a_r, s2a_r, s1b_r, s2b_r} <= 40'h0000000000;
            {wa_r, wb_r} <= 20'h00000;
            pair_r <= 20'h00000;
            tx_r <= 20'h00000;
            {ph_r, gap_r, last_r} <= 12'h000;
            {half_r, lb_r, cad_err_r} <= 3'h0;
        end else begin
            {s1a_r, s2a_r, s1b_r, s2b_r} <= {s1a_nxt, s2a_nxt, s1b_nxt, s2b_nxt};
            {wa_r, wb_r} <= {wa_nxt, wb_nxt};
            pair_r <= pair_nxt;
            tx_r <= tx_nxt;
            {ph_r, gap_r, last_r} <= {ph_nxt, gap_nxt, last_nxt};
            {half_r, lb_r, cad_err_r} <= {half_nxt, lb_nxt, err_nxt};
        end
    end
    assign TXDATA = tx_r;
    assign CADENCE_ERR = cad_err_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    bus_answer_a: assert property (req && wait_r |=> !wait_r ##1 wait_r)
        else $error("waitrequest did not answer in one cycle");
    src_ext_a: assert property (TX_CE && use_ext |=> s1b_r == $past(LINK_B_STREAM1_IN))
        else $error("external stream not selected");
    src_int_a: assert property (TX_CE && !use_ext |=> s2a_r == $past(o2a_r))
        else $error("internal stream not selected");
    f2_ignore_a: assert property (st_r == sdi_out_pkg::PKT_IDLE && TX_CE && FIELD2_IN && !(ins_en && f2_en)
        |=> st_r == sdi_out_pkg::PKT_IDLE)
        else $error("field-2 packet started while gated off");
    f2_insert_a: assert property (st_r == sdi_out_pkg::PKT_IDLE && TX_CE && HANC_START && f2_hit
        |=> st_r == sdi_out_pkg::PKT_SEND && o1a_r == 10'h000)
        else $error("field-2 packet not started");
    sd_bypass_a: assert property (mode == sdi_out_pkg::MODE_SD && bypass
        |=> TXDATA == {$past(s1a_r), 10'h000})
        else $error("bypassed SD word misplaced");
    sd_rep_a: assert property (sd_rep && ph_r == 4'h0 |=> TXDATA[10:0] == {11{$past(pair_r[0])}})
        else $error("first bit not repeated eleven times");
    hd_pack_a: assert property (mode == sdi_out_pkg::MODE_HD |=> TXDATA == {$past(s2a_r), $past(s1a_r)})
        else $error("HD word packing wrong");
    cad_err_a: assert property (sd_rep && TX_CE && (gap_now > `CAD_LONG || gap_now == last_r) ##1 sd_rep
        |-> CADENCE_ERR)
        else $error("bad cadence interval not flagged");
    err_idle_a: assert property (!sd_rep |=> !CADENCE_ERR)
        else $error("cadence error outside SD replication");
    link_b_a: assert property (!dual && TX_CE |=> LINK_B_STREAM1_OUT == 10'h000)
        else $error("link B driven outside dual modes");

    pkt_done_c: cover property (st_r == sdi_out_pkg::PKT_SEND && idx_r == `PKT_LAST && TX_CE);
    cad_bad_c: cover property (sd_rep && CADENCE_ERR);
    ext_sel_c: cover property (use_ext && TX_CE ##1 !use_ext && TX_CE);
endmodule

// *** sdi_app_model.sv ***
// Model of the application side: word clock enable cadence and stream loop-back.
module sdi_app_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sd_mode,
    input wire logic bad_cadence,
    input wire logic [9:0] out_a1,
    input wire logic [9:0] out_a2,
    input wire logic [9:0] out_b1,
    input wire logic [9:0] out_b2,
    output logic tx_ce,
    output logic [9:0] in_a1,
    output logic [9:0] in_a2,
    output logic [9:0] in_b1,
    output logic [9:0] in_b2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] span;
    logic alt_r;
    logic alt_nxt;
    // enable cadence
    // A bad cadence repeats the short interval, which a checker must flag.
    always_comb begin
        span = (alt_r && !bad_cadence) ? 3'h5 : 3'h4;
        cnt_nxt = (cnt_r == span) ? 3'h0 : cnt_r + 3'h1;
        alt_nxt = (cnt_r == span) ? ~alt_r : alt_r;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 3'h0;
            alt_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            alt_r <= alt_nxt;
        end
    end
    assign tx_ce = !sd_mode || cnt_r == 3'h0;
    // ancillary loop-back
    // Flipping bit 0 marks returned words so the bench can tell them from internal ones.
    assign in_a1 = out_a1 ^ 10'h001;
    assign in_a2 = out_a2 ^ 10'h001;
    assign in_b1 = out_b1 ^ 10'h001;
    assign in_b2 = out_b2 ^ 10'h001;
endmodule

// *** tb.sv ***
// Self-checking bench of the SDI output stage.
`include "sdi_out_map.svh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] INS = 32'h1 << `CTRL_INSERT;
    localparam logic [31:0] F2 = 32'h1 << `CTRL_F2EN;
    localparam logic [31:0] EXT = 32'h1 << `CTRL_USEEXT;
    localparam logic [31:0] BYP = 32'h1 << `CTRL_BYPASS;
    logic MCLK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST, TX_CE;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    logic HANC_START = 1'b0, FIELD2_IN = 1'b0, CADENCE_ERR, sd_mode = 1'b0, bad_cadence = 1'b0, prevb;
    logic [10:0] LINE_IN = 11'h000;
    logic [9:0] VID_A_Y_IN = 10'h200, VID_A_C_IN = 10'h2aa, VID_B_Y_IN = 10'h0f0, VID_B_C_IN = 10'h30f;
    logic [9:0] LINK_A_STREAM1_IN, LINK_A_STREAM2_IN, LINK_B_STREAM1_IN, LINK_B_STREAM2_IN;
    logic [9:0] LINK_A_STREAM1_OUT, LINK_A_STREAM2_OUT, LINK_B_STREAM1_OUT, LINK_B_STREAM2_OUT;
    logic [19:0] TXDATA, t0, wa, wb;
    logic [9:0] pkt [0:10];
    logic [8:0] s;
    logic [31:0] mctl [0:3];
    int failures = 0, comparisons = 0, n, m, i, errs, nruns, run;
    always #10 MCLK = ~MCLK;
    sdi_out_stage dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_CE(TX_CE),
        .HANC_START(HANC_START), .LINE_IN(LINE_IN), .FIELD2_IN(FIELD2_IN), .VID_A_Y_IN(VID_A_Y_IN),
        .VID_A_C_IN(VID_A_C_IN), .VID_B_Y_IN(VID_B_Y_IN), .VID_B_C_IN(VID_B_C_IN),
        .LINK_A_STREAM1_IN(LINK_A_STREAM1_IN), .LINK_A_STREAM2_IN(LINK_A_STREAM2_IN),
        .LINK_B_STREAM1_IN(LINK_B_STREAM1_IN), .LINK_B_STREAM2_IN(LINK_B_STREAM2_IN),
        .LINK_A_STREAM1_OUT(LINK_A_STREAM1_OUT), .LINK_A_STREAM2_OUT(LINK_A_STREAM2_OUT),
        .LINK_B_STREAM1_OUT(LINK_B_STREAM1_OUT), .LINK_B_STREAM2_OUT(LINK_B_STREAM2_OUT),
        .TXDATA(TXDATA), .CADENCE_ERR(CADENCE_ERR));
    sdi_app_model model_u (.clk(MCLK), .rst(SYS_RST), .sd_mode(sd_mode), .bad_cadence(bad_cadence),
        .out_a1(LINK_A_STREAM1_OUT), .out_a2(LINK_A_STREAM2_OUT), .out_b1(LINK_B_STREAM1_OUT),
        .out_b2(LINK_B_STREAM2_OUT), .tx_ce(TX_CE), .in_a1(LINK_A_STREAM1_IN),
        .in_a2(LINK_A_STREAM2_IN), .in_b1(LINK_B_STREAM1_IN), .in_b2(LINK_B_STREAM2_IN));
    // ********
    // Tasks
    // ********
    task automatic results();
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [9:0] dw(input logic [7:0] b);
        return {~(^b), ^b, b};
    endfunction
    // The request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int k;
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        for (k = 0; k < 20; k++) begin
            @(posedge MCLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (k == 20) begin
            failures++;
            results();
        end
    endtask
    task automatic ckreg(input logic [4:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0);
        `CHECK("register", ex, rd)
    endtask
    task automatic hanc(input logic [10:0] line, input logic on);
        @(posedge MCLK);
        HANC_START <= 1'b1;
        LINE_IN <= line;
        FIELD2_IN <= 1'b1;
        @(posedge MCLK);
        HANC_START <= 1'b0;
        for (int j = 0; j < 11; j++) begin
            #1;
            `CHECK("link a stream 1", on ? pkt[j] : VID_A_Y_IN, LINK_A_STREAM1_OUT)
            `CHECK("link b stream 1", on ? pkt[j] : VID_B_Y_IN, LINK_B_STREAM1_OUT)
            @(posedge MCLK);
        end
    endtask
    task automatic lat(input logic [9:0] v, input logic [9:0] ex);
        @(posedge MCLK);
        VID_A_Y_IN <= v;
        for (n = 1; n < 10; n++) begin
            @(posedge MCLK);
            #1;
            if (TXDATA[9:0] === ex) break;
        end
    endtask
    initial begin
        repeat (20000) @(posedge MCLK);
        failures++;
        results();
    end
    // ********
    // Sequence
    // ********
    initial begin
        pkt = '{10'h000, 10'h3ff, 10'h3ff, dw(`PKT_DID), dw(`PKT_SDID), dw(`PKT_DC), dw(8'h10), dw(8'h20),
            dw(8'h40), dw(8'h80), 10'h000};
        s = 9'h000;
        for (i = 3; i < 10; i++) s = s + {1'b0, pkt[i][7:0]};
        pkt[10] = {~s[8], s};
        mctl = '{32'h0, 32'h1 | BYP, 32'h2, 32'h6};
        repeat (2) @(posedge MCLK);
        #1;
        `CHECK("idle wait", 1'b1, AVS_WAITREQUEST)
        @(posedge MCLK);
        SYS_RST <= 1'b0;
        ckreg(`OFS_CTRL, `CTRL_RESET);
        ckreg(`OFS_LINES, `LINES_RESET);
        ckreg(`OFS_UDW, `UDW_RESET);
        bus(1'b1, 5'h10, 32'hffff_ffff);
        ckreg(5'h10, 32'h0);
        bus(1'b1, `OFS_LINES, 32'hffff_ffff);
        ckreg(`OFS_LINES, 32'h07ff_07ff);
        AVS_BYTEENABLE <= 4'h4;
        bus(1'b1, `OFS_LINES, 32'h0);
        AVS_BYTEENABLE <= 4'hf;
        ckreg(`OFS_LINES, 32'h0700_07ff);
        bus(1'b1, `OFS_STATUS, 32'hffff_ffff);
        ckreg(`OFS_STATUS, 32'h0);
        bus(1'b1, `OFS_LINES, 32'h0123_0045);
        bus(1'b1, `OFS_UDW, 32'h8040_2010);
        bus(1'b1, `OFS_CTRL, INS | F2);
        hanc(11'h123, 1'b1);
        hanc(11'h124, 1'b0);
        bus(1'b1, `OFS_CTRL, INS);
        hanc(11'h123, 1'b0);
        bus(1'b1, `OFS_CTRL, F2);
        hanc(11'h123, 1'b0);
        bus(1'b1, `OFS_CTRL, 32'h0);
        lat(10'h0c3, 10'h0c3);
        `CHECK("internal latency", 3, n)
        bus(1'b1, `OFS_CTRL, EXT);
        lat(10'h3c0, 10'h3c1);
        `CHECK("external latency", 3, n)
        `CHECK("external stream 2", VID_A_C_IN ^ 10'h001, TXDATA[19:10])
        for (m = 0; m < 4; m++) begin
            bus(1'b1, `OFS_CTRL, mctl[m]);
            sd_mode <= m == 1;
            repeat (30) @(posedge MCLK);
            #1;
            `CHECK("link a stream 1", VID_A_Y_IN, LINK_A_STREAM1_OUT)
            if (m != 1) `CHECK("link a stream 2", VID_A_C_IN, LINK_A_STREAM2_OUT)
            `CHECK("link b stream 1", (m == 0 || m == 3) ? VID_B_Y_IN : 10'h000, LINK_B_STREAM1_OUT)
            `CHECK("link b stream 2", (m == 0 || m == 3) ? VID_B_C_IN : 10'h000, LINK_B_STREAM2_OUT)
            if (m == 1) `CHECK("sd word", {VID_A_Y_IN, 10'h000}, TXDATA)
            if (m == 0 || m == 2) `CHECK("word", {VID_A_C_IN, VID_A_Y_IN}, TXDATA)
            if (m == 3) begin
                wa = {VID_A_C_IN, VID_A_Y_IN};
                wb = {VID_B_C_IN, VID_B_Y_IN};
                t0 = TXDATA;
                @(posedge MCLK);
                #1;
                `CHECK("level b pair", {wa, wb}, (t0 === wa) ? {t0, TXDATA} : {TXDATA, t0})
            end
        end
        @(posedge MCLK);
        VID_A_Y_IN <= 10'h155;
        bus(1'b1, `OFS_CTRL, 32'h1);
        sd_mode <= 1'b1;
        repeat (60) @(posedge MCLK);
        #1;
        prevb = TXDATA[0];
        errs = 0;
        nruns = 0;
        run = 0;
        repeat (44) begin
            @(posedge MCLK);
            #1;
            for (i = 0; i < 20; i++) begin
                if (TXDATA[i] === prevb) run++;
                else begin
                    if (nruns > 0 && run != 11) errs++;
                    nruns++;
                    run = 1;
                    prevb = TXDATA[i];
                end
            end
        end
        `CHECK("bit runs", 1'b1, errs == 0 && nruns > 70)
        `CHECK("cadence good", 1'b0, CADENCE_ERR)
        @(posedge MCLK);
        bad_cadence <= 1'b1;
        repeat (40) @(posedge MCLK);
        #1;
        `CHECK("cadence bad", 1'b1, CADENCE_ERR)
        ckreg(`OFS_STATUS, 32'h1);
        bad_cadence <= 1'b0;
        repeat (40) @(posedge MCLK);
        #1;
        `CHECK("cadence clear", 1'b0, CADENCE_ERR)
        bus(1'b1, `OFS_CTRL, 32'h1 | BYP);
        bad_cadence <= 1'b1;
        repeat (40) @(posedge MCLK);
        #1;
        `CHECK("cadence bypassed", 1'b0, CADENCE_ERR)
        results();
    end
endmodule
